//--- rtl/rsc_reset_ctrl.sv
// Purpose: system reset controller: cause flags, reset sequencing, software resets
// Assumes: all inputs synchronous to clk; slow 32 kHz rate derived as an enable
// Notes:   general purpose words are deliberately left out of reset
//
// Functional notes
// - mix reset stretched 1..4 times 88 cycles
// - warm reset waits 16/32/64 slow ticks
// - no ack by timeout: cold reset; or wait forever
// - third watchdog resets core or whole system
// - third watchdog path enabled at reset, maskable
// - core software reset bit self-clears when done
// - separate debug-only software reset reporting done
// - sensor reset enabled; flag hardware-reset cleared
// - sensor flag kept while sensor interrupt pending
// - watchdog path enabled; masked event no reset
// - masked watchdog flag clears only on reset
// - memory interface reset bit never self-clears
// - lockup enables: lockup, lockup or request
// - storage unit failure always cold, flagged
// - one flag per hardware reset source
// - debug port, debug register, boundary scan flags
// - core request and lockup cause flags
// - status shows reset output pin enable
// - general purpose words survive reset
// - two boot words reflect pins and fuses
// - status bit shows core 0 watchdog request
// - optional debug reset after power gating
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module rsc_reset_ctrl #(
	parameter int unsigned GPR_COUNT = 10,
	parameter int unsigned FUSE_W    = 30
) (
	input  wire logic                 clk,
	input  wire logic                 reset,
	// register port
	input  wire logic [7:0]           addr,
	input  wire logic [31:0]          wr_data,
	input  wire logic                 wr_en,
	input  wire logic                 rd_en,
	output logic      [31:0]          rd_data,
	// reset sources
	input  wire logic                 por_detect,
	input  wire logic                 reset_pin_req,
	input  wire logic                 user_reset_req,
	input  wire logic                 csu_reset_req,
	input  wire logic                 wdog_event,
	input  wire logic                 third_watchdog_reset_n,
	input  wire logic                 temp_reset_req,
	input  wire logic                 temp_irq_pending,
	input  wire logic                 core_system_reset_request,
	input  wire logic                 core_lockup,
	input  wire logic                 debug_sys_reset_req,
	input  wire logic                 debug_ctrl_general_reg_b31,
	input  wire logic                 boundary_scan_reset,
	input  wire logic                 secure_nv_storage_unit_fail,
	input  wire logic                 power_gate_event,
	input  wire logic                 core0_wdog_req,
	input  wire logic                 dram_controller_ack,
	input  wire logic [31:0]          boot_config_pins,
	input  wire logic [1:0]           boot_select_pins,
	input  wire logic [FUSE_W-1:0]    boot_fuses,
	// reset outputs
	output logic                      sys_cold_reset,
	output logic                      sys_warm_reset,
	output logic                      mix_reset,
	output logic                      warm_reset_pending,
	output logic                      core_reset,
	output logic                      core_debug_reset,
	output logic                      emi_reset,
	output logic                      reset_out_pin
);

	localparam int unsigned NF = rsc_pkg::NUM_FLAGS;
	// index width of the general purpose array, so a word select never overhangs it
	localparam int unsigned GW = (GPR_COUNT > 1) ? $clog2(GPR_COUNT) : 1;

	// one-hot cause mask
	function automatic logic [NF-1:0] fbit(input int unsigned pos);
		logic [NF-1:0] m;
		m = '0;
		m[pos] = 1'b1;
		return m;
	endfunction

	// register select
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	rsc_pkg::rsc_ctrl_t   ctrl_r;
	rsc_pkg::rsc_state_t  state_r;
	logic [NF-1:0]        flags_r;
	logic [NF-1:0]        src_prev_r;
	logic                 wdog_sticky_r;
	logic                 pg_prev_r;
	logic                 cold_pend_r;
	logic [11:0]          div_cnt_r;
	logic                 slow_tick_r;
	logic [6:0]           byp_cnt_r;
	logic [8:0]           str_cnt_r;
	logic [4:0]           core_cnt_r;
	logic [4:0]           dbg_cnt_r;
	logic [31:0]          boot1_r;
	logic [31:0]          boot2_r;
	logic [31:0]          gpr_r [GPR_COUNT];

	logic [NF-1:0] src_vec;
	logic [NF-1:0] rise;
	logic [NF-1:0] trig;
	logic [NF-1:0] flag_set;
	logic [NF-1:0] flag_clr;
	logic [NF-1:0] clearable;
	logic          cold_trig;
	logic          warm_trig;
	logic          wdog3_core;
	logic          wdog_masked;
	logic          ctrl_wr;
	logic [6:0]    byp_limit;
	logic [8:0]    str_limit;
	logic          gpr_sel;
	logic [7:0]    gpr_idx;

	// raw source levels; third watchdog is active low
	always_comb
	begin
		src_vec                  = '0;
		src_vec[rsc_pkg::F_POR]     = por_detect;
		src_vec[rsc_pkg::F_PIN]     = reset_pin_req;
		src_vec[rsc_pkg::F_USER]    = user_reset_req;
		src_vec[rsc_pkg::F_CSU]     = csu_reset_req;
		src_vec[rsc_pkg::F_WDOG]    = wdog_event;
		src_vec[rsc_pkg::F_WDOG3]   = ~third_watchdog_reset_n;
		src_vec[rsc_pkg::F_TEMP]    = temp_reset_req;
		src_vec[rsc_pkg::F_SECURE_NV_STORAGE_UNIT]    = secure_nv_storage_unit_fail;
		src_vec[rsc_pkg::F_SWREQ]   = core_system_reset_request;
		src_vec[rsc_pkg::F_LOCKUP]  = core_lockup;
		src_vec[rsc_pkg::F_LOCKSYS] = 1'b0;
		src_vec[rsc_pkg::F_DBGSYS]  = debug_sys_reset_req;
		src_vec[rsc_pkg::F_DBGGPR]  = debug_ctrl_general_reg_b31;
		src_vec[rsc_pkg::F_BSCAN]   = boundary_scan_reset;
	end

	// edge detect so a held request fires once
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			src_prev_r <= '0;
			pg_prev_r  <= 1'b0;
		end
		else
		begin
			src_prev_r <= src_vec;
			pg_prev_r  <= power_gate_event;
		end
	end

	assign rise = src_vec & ~src_prev_r;

	// gate rising watchdog, third watchdog, sensor and lockup by their enables; lock-system takes lockup or request when enabled; others pass ungated
	always_comb
	begin
		trig = rise;
		trig[rsc_pkg::F_WDOG]   = rise[rsc_pkg::F_WDOG] & ctrl_r.wdog_en;
		trig[rsc_pkg::F_WDOG3]  = rise[rsc_pkg::F_WDOG3] & ctrl_r.wdog3_en;
		trig[rsc_pkg::F_TEMP]   = rise[rsc_pkg::F_TEMP] & ctrl_r.temp_en;
		trig[rsc_pkg::F_LOCKUP] = rise[rsc_pkg::F_LOCKUP] & ctrl_r.lockup_en;
		trig[rsc_pkg::F_LOCKSYS] = ctrl_r.lockup_sys_en
			& (rise[rsc_pkg::F_LOCKUP] | rise[rsc_pkg::F_SWREQ]);
	end

	assign wdog_masked = rise[rsc_pkg::F_WDOG] & ~ctrl_r.wdog_en;
	assign wdog3_core  = trig[rsc_pkg::F_WDOG3] & ~ctrl_r.wdog3_global;
	// hardware-fatal sources go straight to cold reset
	assign cold_trig = |(trig & (fbit(rsc_pkg::F_POR) | fbit(rsc_pkg::F_PIN)
		| fbit(rsc_pkg::F_USER) | fbit(rsc_pkg::F_CSU) | fbit(rsc_pkg::F_SECURE_NV_STORAGE_UNIT)));
	assign warm_trig = |(trig & ~fbit(rsc_pkg::F_WDOG3)) | (trig[rsc_pkg::F_WDOG3]
		& ctrl_r.wdog3_global);

	// flags record a cause only when that cause acts; masked watchdog still flags
	always_comb
	begin
		flag_set = '0;
		if (state_r == rsc_pkg::ST_IDLE || trig[rsc_pkg::F_SECURE_NV_STORAGE_UNIT])
		begin
			flag_set = trig;
		end
		if (wdog_masked)
		begin
			flag_set[rsc_pkg::F_WDOG] = 1'b1;
		end
	end

	// sensor flag and masked watchdog flag only clear on hardware reset
	always_comb
	begin
		clearable = ~fbit(rsc_pkg::F_TEMP);
		// a pending sensor interrupt pins the sensor flag as well
		if (temp_irq_pending)
		begin
			clearable[rsc_pkg::F_TEMP] = 1'b0;
		end
		if (wdog_sticky_r)
		begin
			clearable[rsc_pkg::F_WDOG] = 1'b0;
		end
	end

	assign ctrl_wr  = wr_en && hit(addr, rsc_pkg::OFS_CTRL);
	assign flag_clr = (wr_en && hit(addr, rsc_pkg::OFS_FLAGS))
		? (wr_data[NF-1:0] & clearable) : '0;

	// sticky cause flags; a new event beats a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			flags_r       <= '0;
			wdog_sticky_r <= 1'b0;
		end
		else
		begin
			flags_r <= (flags_r & ~flag_clr) | flag_set;
			if (wdog_masked)
			begin
				wdog_sticky_r <= 1'b1;
			end
		end
	end

	// control register; command bits clear themselves on completion
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctrl_r <= rsc_pkg::CTRL_RESET;
		end
		else
		begin
			if (ctrl_wr)
			begin
				ctrl_r <= rsc_pkg::rsc_ctrl_t'(wr_data[14:0]);
				// a write cannot cancel a running command
				if (ctrl_r.core_sw_rst)
				begin
					ctrl_r.core_sw_rst <= 1'b1;
				end
				if (ctrl_r.dbg_sw_rst)
				begin
					ctrl_r.dbg_sw_rst <= 1'b1;
				end
			end
			else
			begin
				if (ctrl_r.core_sw_rst && core_cnt_r == 5'(rsc_pkg::CORE_RST_CYCLES))
				begin
					ctrl_r.core_sw_rst <= 1'b0;
				end
				if (ctrl_r.dbg_sw_rst && dbg_cnt_r == 5'(rsc_pkg::CORE_RST_CYCLES))
				begin
					ctrl_r.dbg_sw_rst <= 1'b0;
				end
			end
		end
	end

	// core reset timer: software command or third watchdog in core mode
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			core_cnt_r <= '0;
			core_reset <= 1'b0;
		end
		else if (ctrl_r.core_sw_rst && core_cnt_r != 5'(rsc_pkg::CORE_RST_CYCLES))
		begin
			core_cnt_r <= core_cnt_r + 5'h01;
			core_reset <= 1'b1;
		end
		else if (wdog3_core)
		begin
			core_cnt_r <= '0;
			core_reset <= 1'b1;
		end
		else
		begin
			core_cnt_r <= ctrl_r.core_sw_rst ? core_cnt_r : 5'h00;
			core_reset <= 1'b0;
		end
	end

	// debug-only reset: software command or power gating when enabled
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			dbg_cnt_r        <= '0;
			core_debug_reset <= 1'b0;
		end
		else if (ctrl_r.dbg_sw_rst && dbg_cnt_r != 5'(rsc_pkg::CORE_RST_CYCLES))
		begin
			dbg_cnt_r        <= dbg_cnt_r + 5'h01;
			core_debug_reset <= 1'b1;
		end
		else
		begin
			dbg_cnt_r        <= ctrl_r.dbg_sw_rst ? dbg_cnt_r : 5'h00;
			core_debug_reset <= ctrl_r.dbg_after_pg_en
				& power_gate_event & ~pg_prev_r;
		end
	end

	// slow tick divider; free running so the wait starts on any phase
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			div_cnt_r   <= '0;
			slow_tick_r <= 1'b0;
		end
		else if (div_cnt_r == 12'(rsc_pkg::SLOW_DIV - 1))
		begin
			div_cnt_r   <= '0;
			slow_tick_r <= 1'b1;
		end
		else
		begin
			div_cnt_r   <= div_cnt_r + 12'h001;
			slow_tick_r <= 1'b0;
		end
	end

	// bypass limit and stretch width from control
	always_comb
	begin
		case (ctrl_r.bypass_sel)
			rsc_pkg::BYP_16: byp_limit = 7'(rsc_pkg::BYPASS_16);
			rsc_pkg::BYP_32: byp_limit = 7'(rsc_pkg::BYPASS_32);
			rsc_pkg::BYP_64: byp_limit = 7'(rsc_pkg::BYPASS_64);
			default:         byp_limit = 7'h00;                                 // wait forever
		endcase
		str_limit = 9'(rsc_pkg::STRETCH_UNIT) * (9'(ctrl_r.stretch_sel) + 9'h001);
	end

	// system sequencer: warm wait for ack, then assert with stretched mix reset
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r     <= rsc_pkg::ST_IDLE;
			byp_cnt_r   <= '0;
			str_cnt_r   <= '0;
			cold_pend_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				rsc_pkg::ST_IDLE:
				begin
					byp_cnt_r <= '0;
					str_cnt_r <= '0;
					if (cold_trig)
					begin
						cold_pend_r <= 1'b1;
						state_r     <= rsc_pkg::ST_ASSERT;
					end
					else if (warm_trig)
					begin
						cold_pend_r <= 1'b0;
						state_r     <= rsc_pkg::ST_WARM_WAIT;
					end
				end
				rsc_pkg::ST_WARM_WAIT:
				begin
					if (trig[rsc_pkg::F_SECURE_NV_STORAGE_UNIT])
					begin
						cold_pend_r <= 1'b1;
						state_r     <= rsc_pkg::ST_ASSERT;
					end
					else if (dram_controller_ack)
					begin
						state_r    <= rsc_pkg::ST_ASSERT;
					end
					else if (byp_limit != 7'h00 && byp_cnt_r == byp_limit)
					begin
						cold_pend_r <= 1'b1;
						state_r     <= rsc_pkg::ST_ASSERT;
					end
					else if (slow_tick_r && byp_limit != 7'h00)
					begin
						byp_cnt_r <= byp_cnt_r + 7'h01;
					end
				end
				rsc_pkg::ST_ASSERT:
				begin
					if (trig[rsc_pkg::F_SECURE_NV_STORAGE_UNIT])
					begin
						cold_pend_r <= 1'b1;
						str_cnt_r   <= '0;
					end
					else if (str_cnt_r == str_limit - 9'h001)
					begin
						state_r    <= rsc_pkg::ST_IDLE;
					end
					else
					begin
						str_cnt_r <= str_cnt_r + 9'h001;
					end
				end
				default:
				begin
					state_r <= rsc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// registered reset outputs
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sys_cold_reset     <= 1'b0;
			sys_warm_reset     <= 1'b0;
			mix_reset          <= 1'b0;
			warm_reset_pending <= 1'b0;
			emi_reset          <= 1'b0;
			reset_out_pin      <= 1'b0;
		end
		else
		begin
			sys_cold_reset     <= state_r == rsc_pkg::ST_ASSERT && cold_pend_r;
			sys_warm_reset     <= state_r == rsc_pkg::ST_ASSERT && !cold_pend_r;
			mix_reset          <= state_r == rsc_pkg::ST_ASSERT;
			warm_reset_pending <= state_r == rsc_pkg::ST_WARM_WAIT;
			emi_reset          <= ctrl_r.emi_rst;
			reset_out_pin      <= ctrl_r.reset_out_en
				&& state_r == rsc_pkg::ST_ASSERT;
		end
	end

	// boot words sampled every cycle
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			boot1_r <= '0;
			boot2_r <= '0;
		end
		else
		begin
			boot1_r <= boot_config_pins;
			boot2_r <= 32'({boot_fuses, boot_select_pins});
		end
	end

	assign gpr_sel = addr >= rsc_pkg::OFS_GPR && addr[1:0] == 2'h0
		&& (addr - rsc_pkg::OFS_GPR) < 8'(GPR_COUNT * 4);
	assign gpr_idx = (addr - rsc_pkg::OFS_GPR) >> 2;

	// general purpose words have no reset so their content survives it
	always_ff @(posedge clk)
	begin
		if (wr_en && gpr_sel)
		begin
			gpr_r[gpr_idx[GW-1:0]] <= wr_data;
		end
	end

	// read data one cycle after the strobe; zero otherwise
	always_ff @(posedge clk)
	begin
		if (reset || !rd_en)
		begin
			rd_data <= '0;
		end
		else if (gpr_sel)
		begin
			rd_data <= gpr_r[gpr_idx[GW-1:0]];
		end
		else
		begin
			case (addr)
				rsc_pkg::OFS_CTRL:  rd_data <= 32'(ctrl_r);
				rsc_pkg::OFS_FLAGS: rd_data <= 32'(flags_r);
				rsc_pkg::OFS_STAT:
				begin
					rd_data <= '0;
					rd_data[rsc_pkg::S_CORE0_WDOG] <= core0_wdog_req;
					rd_data[rsc_pkg::S_RSTOUT_EN]  <= ctrl_r.reset_out_en;
					rd_data[rsc_pkg::S_CORE_DONE]  <= ~ctrl_r.core_sw_rst;
					rd_data[rsc_pkg::S_DBG_DONE]   <= ~ctrl_r.dbg_sw_rst;
					rd_data[rsc_pkg::S_WARM_WAIT]  <= state_r == rsc_pkg::ST_WARM_WAIT;
				end
				rsc_pkg::OFS_BOOT1: rd_data <= boot1_r;
				rsc_pkg::OFS_BOOT2: rd_data <= boot2_r;
				default:            rd_data <= '0;
			endcase
		end
	end

endmodule

`default_nettype wire

//--- rtl/rsc_pkg.sv
// Purpose: shared constants and types of the system reset controller
// Assumes: one 100 MHz clock, register port with 32-bit data
// Notes:   offsets are byte addresses of aligned words
package rsc_pkg;

	// clock and slow tick
	localparam int unsigned CLK_HZ      = 100000000;
	localparam int unsigned SLOW_HZ     = 32768;
	localparam int unsigned SLOW_DIV    = CLK_HZ / SLOW_HZ;   // rounds down
	localparam int unsigned STRETCH_UNIT = 88;               // clock cycles per stretch step
	localparam int unsigned BYPASS_16   = 16;
	localparam int unsigned BYPASS_32   = 32;
	localparam int unsigned BYPASS_64   = 64;
	localparam int unsigned CORE_RST_CYCLES = 16;

	// register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_FLAGS  = 8'h04;
	localparam logic [7:0] OFS_STAT   = 8'h08;
	localparam logic [7:0] OFS_BOOT1  = 8'h0C;
	localparam logic [7:0] OFS_BOOT2  = 8'h10;
	localparam logic [7:0] OFS_GPR    = 8'h20;

	// reset-cause flag positions
	localparam int unsigned NUM_FLAGS  = 14;
	localparam int unsigned F_POR      = 0;
	localparam int unsigned F_PIN      = 1;
	localparam int unsigned F_USER     = 2;
	localparam int unsigned F_CSU      = 3;
	localparam int unsigned F_WDOG     = 4;
	localparam int unsigned F_WDOG3    = 5;
	localparam int unsigned F_TEMP     = 6;
	localparam int unsigned F_SECURE_NV_STORAGE_UNIT     = 7;
	localparam int unsigned F_SWREQ    = 8;
	localparam int unsigned F_LOCKUP   = 9;
	localparam int unsigned F_LOCKSYS  = 10;
	localparam int unsigned F_DBGSYS   = 11;
	localparam int unsigned F_DBGGPR   = 12;
	localparam int unsigned F_BSCAN    = 13;

	// status register positions
	localparam int unsigned S_CORE0_WDOG = 0;
	localparam int unsigned S_RSTOUT_EN  = 1;
	localparam int unsigned S_CORE_DONE  = 2;
	localparam int unsigned S_DBG_DONE   = 3;
	localparam int unsigned S_WARM_WAIT  = 4;

	// warm bypass selection
	localparam logic [1:0] BYP_ALWAYS = 2'h0;
	localparam logic [1:0] BYP_16     = 2'h1;
	localparam logic [1:0] BYP_32     = 2'h2;
	localparam logic [1:0] BYP_64     = 2'h3;

	// control register layout, lsb last
	typedef struct packed {
		logic       reset_out_en;    // [14]
		logic       dbg_after_pg_en; // [13]
		logic       lockup_sys_en;   // [12]
		logic       lockup_en;       // [11]
		logic       emi_rst;         // [10]
		logic       wdog_en;         // [9]
		logic       temp_en;         // [8]
		logic       dbg_sw_rst;      // [7]
		logic       core_sw_rst;     // [6]
		logic       wdog3_en;        // [5]
		logic       wdog3_global;    // [4]
		logic [1:0] bypass_sel;      // [3:2]
		logic [1:0] stretch_sel;     // [1:0]
	} rsc_ctrl_t;

	localparam rsc_ctrl_t CTRL_RESET = 15'h0320;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WARM_WAIT,
		ST_ASSERT
	} rsc_state_t;

endpackage

//--- sim/rsc_checker.sv
// Purpose: port-level assertions for the reset controller
// Assumes: one clk domain, synchronous active-high reset
// Notes:   run-length counters sit beside the assertions
`timescale 1ns/10ps
`default_nettype none

module rsc_checker (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wr_data,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [31:0] rd_data,
	input wire logic        por_detect,
	input wire logic        secure_nv_storage_unit_fail,
	input wire logic        dram_controller_ack,
	input wire logic        sys_cold_reset,
	input wire logic        sys_warm_reset,
	input wire logic        mix_reset,
	input wire logic        warm_reset_pending,
	input wire logic        core_reset,
	input wire logic        emi_reset,
	input wire logic        reset_out_pin
);
	logic [9:0] mix_cnt_r;
	logic [9:0] core_cnt_r;
	logic       emi_clr_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// run lengths; cleared whenever the output is low
	always_ff @(posedge clk)
	begin
		mix_cnt_r  <= mix_reset ? mix_cnt_r + 10'h001 : 10'h000;
		core_cnt_r <= core_reset ? core_cnt_r + 10'h001 : 10'h000;
	end

	// a write that drops the memory interface reset bit
	always_ff @(posedge clk)
	begin
		emi_clr_r <= wr_en && addr == rsc_pkg::OFS_CTRL && !wr_data[10];
	end

	sequence s_idle;
		!mix_reset && !warm_reset_pending;
	endsequence

	sequence s_cold_up;
		sys_cold_reset && mix_reset;
	endsequence

	a_read_idle_zero: assert property (!$past(rd_en) |-> rd_data == 32'h00000000)
		else $error("read data not zero outside a read answer");
	a_mix_width: assert property ($fell(mix_reset) |-> mix_cnt_r == 10'h058 ||
		mix_cnt_r == 10'h0B0 || mix_cnt_r == 10'h108 || mix_cnt_r == 10'h160)
		else $error("mix reset width not a multiple step");
	a_por_cold: assert property ($rose(por_detect) ##0 s_idle |-> ##[1:3] s_cold_up)
		else $error("power-on detect did not start a cold reset");
	a_fail_cold: assert property
		($rose(secure_nv_storage_unit_fail) ##0 s_idle |-> ##[1:3] s_cold_up)
		else $error("storage failure did not start a cold reset");
	a_one_kind: assert property (!(sys_cold_reset && sys_warm_reset))
		else $error("cold and warm reset together");
	a_ack_warm: assert property (warm_reset_pending && dram_controller_ack
		|-> ##[1:3] sys_warm_reset)
		else $error("acknowledge did not release the warm reset");
	a_wait_ends: assert property ($fell(warm_reset_pending)
		|-> ##[0:2] (sys_cold_reset || sys_warm_reset))
		else $error("warm wait ended without a reset");
	a_emi_held: assert property ($fell(emi_reset) |-> $past(emi_clr_r))
		else $error("memory interface reset dropped by itself");
	a_core_width: assert property ($fell(core_reset)
		|-> core_cnt_r == 10'h010 || core_cnt_r == 10'h001)
		else $error("core reset width wrong");
	a_pin_in_assert: assert property (reset_out_pin |-> sys_cold_reset || sys_warm_reset)
		else $error("reset output pin high outside a reset");
endmodule

bind rsc_reset_ctrl rsc_checker u_rsc_checker (.clk, .reset, .addr, .wr_data, .wr_en,
	.rd_en, .rd_data, .por_detect, .secure_nv_storage_unit_fail, .dram_controller_ack,
	.sys_cold_reset, .sys_warm_reset, .mix_reset, .warm_reset_pending, .core_reset,
	.emi_reset, .reset_out_pin);

`default_nettype wire

//--- sim/rsc_dram_partner.sv
// Purpose: memory controller acknowledge model for warm resets
// Assumes: acknowledge is a level held while the wait lasts
// Notes:   a delay of zero never answers, to force the bypass path
`timescale 1ns/10ps
`default_nettype none

module rsc_dram_partner (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       pending,
	input  wire logic [7:0] ack_dly,
	output logic            ack_r
);
	logic [7:0] cnt_r;

	// answer ack_dly cycles into the wait; drops as soon as the wait ends
	always_ff @(posedge clk)
	begin
		if (reset || !pending)
		begin
			cnt_r <= 8'h00;
			ack_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_r + 8'h01;
			ack_r <= ack_r || (ack_dly != 8'h00 && cnt_r == ack_dly);
		end
	end
endmodule

`default_nettype wire

//--- sim/rsc_reset_ctrl_tb_top.sv
// Purpose: self-checking bench for the reset controller
// Assumes: reads answered one cycle later, checked from a queue
// Notes:   one bypass timeout run costs about 49k cycles
`timescale 1ns/10ps
`default_nettype none

module rsc_reset_ctrl_tb_top;
	localparam int FLAG_OF [14] = '{0, 1, 2, 3, 7, 4, 6, 8, 9, 11, 12, 13, 5, 0};
	logic        clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rd_seen_r = 1'b0;
	logic [7:0]  addr = 8'h00, ack_dly = 8'h04;
	logic [31:0] wr_data = 32'h00000000, rd_data, boot_config_pins = 32'h00000000;
	logic [13:0] src_r = 14'h0000;
	logic [1:0]  boot_select_pins = 2'h0;
	logic [29:0] boot_fuses = 30'h00000000;
	logic        core0_r = 1'b1;
	logic        sys_cold_reset, sys_warm_reset, mix_reset, warm_reset_pending, ack_r;
	logic        core_reset, core_debug_reset, emi_reset, reset_out_pin;
	logic [31:0] exp_q [$];
	int          seed, mismatches = 0, tests_run = 0, cycles = 0, pin_cyc = 0;
	wire  [2:0]  outs = {core_debug_reset, core_reset, mix_reset};

	rsc_reset_ctrl u_rsc_reset_ctrl (.clk, .reset, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
		.por_detect(src_r[0]), .reset_pin_req(src_r[1]), .user_reset_req(src_r[2]),
		.csu_reset_req(src_r[3]), .secure_nv_storage_unit_fail(src_r[4]),
		.wdog_event(src_r[5]), .temp_reset_req(src_r[6]),
		.core_system_reset_request(src_r[7]), .core_lockup(src_r[8]),
		.debug_sys_reset_req(src_r[9]), .debug_ctrl_general_reg_b31(src_r[10]),
		.boundary_scan_reset(src_r[11]), .third_watchdog_reset_n(!src_r[12]),
		.power_gate_event(src_r[13]), .temp_irq_pending(1'b1), .core0_wdog_req(core0_r),
		.dram_controller_ack(ack_r), .boot_config_pins, .boot_select_pins, .boot_fuses,
		.sys_cold_reset, .sys_warm_reset, .mix_reset, .warm_reset_pending, .core_reset,
		.core_debug_reset, .emi_reset, .reset_out_pin);

	rsc_dram_partner u_rsc_dram_partner (.clk, .reset, .pending(warm_reset_pending),
		.ack_dly, .ack_r);

	// free-running clock, 10 ns period
	always #5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("counts: tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// the answer is noted now and compared by the watcher below
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd_en <= 1'b0;
	endtask

	// pulse source i, then time how long output k stays high
	task automatic fire(input int i, input int k, input int m, output int w, output logic c);
		int n;
		n = 0;
		w = 0;
		c = 1'b0;
		@(posedge clk);
		src_r[i] <= 1'b1;
		@(posedge clk);
		src_r[i] <= 1'b0;
		while (outs[k] !== 1'b1 && n < m)
		begin
			@(posedge clk);
			n++;
		end
		while (outs[k] === 1'b1 && w < 400)
		begin
			c = c | sys_cold_reset;
			w++;
			@(posedge clk);
		end
	endtask

	// read answers stand only in the cycle after the strobe
	always @(posedge clk)
	begin
		if (rd_seen_r)
			check(rd_data, exp_q.pop_front());
		rd_seen_r <= rd_en;
	end

	// hang guard; also counts cycles with the reset output pin high
	always @(posedge clk)
	begin
		cycles++;
		if (reset_out_pin === 1'b1)
			pin_cyc++;
		if (cycles == 80000)
		begin
			mismatches++;
			results();
		end
	end

	initial
	begin
		int w;
		logic c;
		logic [31:0] fl;
		logic [31:0] g;
		seed = 32'h6c1c75cf;
		g = $random(seed);
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		boot_config_pins <= $random(seed);
		{boot_fuses, boot_select_pins} <= $random(seed);
		rd(rsc_pkg::OFS_CTRL, 32'h00000320);
		rd(rsc_pkg::OFS_FLAGS, 32'h00000000);
		wr(8'h14, 32'hFFFFFFFF);
		rd(8'h14, 32'h00000000);
		rd(rsc_pkg::OFS_BOOT1, boot_config_pins);
		rd(rsc_pkg::OFS_BOOT2, {boot_fuses, boot_select_pins});
		wr(rsc_pkg::OFS_GPR + 8'h04, g);
		$display("test registers done");
		wr(rsc_pkg::OFS_CTRL, 32'h00000360);
		fire(13, 1, 100, w, c);
		check(32'(w), 32'h00000010);
		rd(rsc_pkg::OFS_CTRL, 32'h00000320);
		wr(rsc_pkg::OFS_CTRL, 32'h000003A0);
		fire(13, 2, 100, w, c);
		check(32'(w), 32'h00000010);
		rd(rsc_pkg::OFS_STAT, 32'h0000000D);
		wr(rsc_pkg::OFS_CTRL, 32'h00002320);
		fire(13, 2, 100, w, c);
		check(32'(w), 32'h00000001);
		fire(12, 1, 100, w, c);
		check(32'(w), 32'h00000001);
		$display("test software resets done");
		wr(rsc_pkg::OFS_CTRL, 32'h00000120);
		fire(5, 0, 300, w, c);
		check(32'(w), 32'h00000000);
		rd(rsc_pkg::OFS_FLAGS, 32'h00000030);
		wr(rsc_pkg::OFS_FLAGS, 32'hFFFFFFFF);
		rd(rsc_pkg::OFS_FLAGS, 32'h00000010);
		$display("test masked watchdog done");
		fl = 32'h00000010;
		for (int i = 0; i < 13; i++)
		begin
			wr(rsc_pkg::OFS_CTRL, 32'h00005B30 | 32'(i % 4));
			fl = fl | (32'h1 << FLAG_OF[i]) | (i == 7 ? 32'h1 << rsc_pkg::F_LOCKSYS : 32'h0);
			fire(i, 0, 2000, w, c);
			check(32'(w), 32'(88 * (i % 4 + 1)));
			check({31'h0, c}, {31'h0, (i < 5)});
			rd(rsc_pkg::OFS_FLAGS, fl);
		end
		rd(rsc_pkg::OFS_GPR + 8'h04, g);
		core0_r <= 1'b0;
		rd(rsc_pkg::OFS_STAT, 32'h0000000E);
		check(32'(pin_cyc), 32'(rsc_pkg::STRETCH_UNIT * 31));
		wr(rsc_pkg::OFS_FLAGS, 32'hFFFFFFFF);
		rd(rsc_pkg::OFS_FLAGS, 32'h00000050);
		$display("test reset sources done");
		wr(rsc_pkg::OFS_CTRL, 32'h00000720);
		repeat (20) @(posedge clk);
		check({31'h0, emi_reset}, 32'h00000001);
		wr(rsc_pkg::OFS_CTRL, 32'h00000324);
		repeat (3) @(posedge clk);
		check({31'h0, emi_reset}, 32'h00000000);
		ack_dly <= 8'h00;
		fire(5, 0, 60000, w, c);
		check({31'h0, c}, 32'h00000001);
		check(32'(w), 32'h00000058);
		$display("test bypass timeout done");
		repeat (3) @(posedge clk);
		results();
	end
endmodule

`default_nettype wire
